// >>> sfcd_pkg.sv
package sfcd_pkg;

  // Opcodes
  localparam logic [7:0] OP_RD   = 8'h03;
  localparam logic [7:0] OP_FRD  = 8'h0B;
  localparam logic [7:0] OP_2IO  = 8'hBB;
  localparam logic [7:0] OP_DOUT = 8'h3B;
  localparam logic [7:0] OP_4IO  = 8'hEB;
  localparam logic [7:0] OP_QOUT = 8'h6B;
  localparam logic [7:0] OP_PP   = 8'h02;
  localparam logic [7:0] OP_QPP  = 8'h38;
  localparam logic [7:0] OP_SEC  = 8'h20;
  localparam logic [7:0] OP_HBLK = 8'h52;
  localparam logic [7:0] OP_BLK  = 8'hD8;
  localparam logic [7:0] OP_CE0  = 8'h60;
  localparam logic [7:0] OP_CE1  = 8'hC7;
  localparam logic [7:0] OP_QEN  = 8'h35;
  localparam logic [7:0] OP_QEX  = 8'hF5;

  // Launch codes on the operation port
  localparam logic [2:0] EX_PGM  = 3'h0;
  localparam logic [2:0] EX_SEC  = 3'h1;
  localparam logic [2:0] EX_HBLK = 3'h2;
  localparam logic [2:0] EX_BLK  = 3'h3;
  localparam logic [2:0] EX_CHIP = 3'h4;
  localparam logic [2:0] EX_QEN  = 3'h5;
  localparam logic [2:0] EX_QEX  = 3'h6;

  // Dummy cycles per setting, nibble index = {msb, lsb}
  localparam logic [15:0] DUMMY_1L  = 16'hA868;
  localparam logic [15:0] DUMMY_2IO = 16'hA864;
  localparam logic [15:0] DUMMY_4IO = 16'hA846;

  localparam logic [5:0] ABITS_NARROW = 6'h18;
  localparam logic [5:0] ABITS_WIDE   = 6'h20;
  localparam logic [5:0] BYTE_BITS    = 6'h08;

  localparam logic [1:0] K_READ = 2'h0;
  localparam logic [1:0] K_PGM  = 2'h1;
  localparam logic [1:0] K_ERAS = 2'h2;
  localparam logic [1:0] K_NOAD = 2'h3;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01, S_OPC = 8'h02, S_ADDR = 8'h04, S_DUMMY = 8'h08,
    S_RDATA = 8'h10, S_WDATA = 8'h20, S_WAIT = 8'h40, S_IGN = 8'h80
  } sfcd_state_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] clk_s;
    logic [3:0] io_a;
    logic [3:0] io_b;
    sfcd_state_t state;
    logic [7:0] op;
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [3:0] dleft;
    logic [7:0] tx;
    logic [3:0] txn;
    logic [31:0] addr;
    logic [3:0] dout;
    logic [3:0] oe;
    logic pgm_v;
    logic [7:0] pgm_d;
    logic [31:0] pgm_a;
    logic pgm_any;
    logic ex_v;
    logic [2:0] ex_op;
    logic rej;
    logic quad;
  } sfcd_regs_t;

  function automatic logic [1:0] cmd_kind(input logic [7:0] op);
    case (op)
      OP_PP, OP_QPP: cmd_kind = K_PGM;
      OP_SEC, OP_HBLK, OP_BLK: cmd_kind = K_ERAS;
      OP_CE0, OP_CE1, OP_QEN, OP_QEX: cmd_kind = K_NOAD;
      default: cmd_kind = K_READ;
    endcase
  endfunction

  function automatic logic cmd_valid(input logic [7:0] op, input logic quad);
    case (op)
      OP_RD, OP_FRD, OP_2IO: cmd_valid = !quad; // RULE7 RULE16
      OP_DOUT, OP_QOUT: cmd_valid = !quad; // RULE8
      OP_QPP, OP_QEN: cmd_valid = !quad; // RULE2
      OP_4IO, OP_PP, OP_SEC, OP_HBLK, OP_BLK: cmd_valid = 1'b1; // RULE9 RULE1 RULE3 RULE4 RULE5
      OP_CE0, OP_CE1: cmd_valid = 1'b1; // RULE6
      OP_QEX: cmd_valid = quad;
      default: cmd_valid = 1'b0; // RULE15
    endcase
  endfunction

  // Lines per beat in address phase
  function automatic logic [2:0] addr_w(input logic [7:0] op, input logic quad);
    if (quad || op == OP_4IO) begin
      addr_w = 3'h4;
    end else if (op == OP_2IO) begin
      addr_w = 3'h2;
    end else begin
      addr_w = 3'h1;
    end
  endfunction

  // Lines per beat in data phase
  function automatic logic [2:0] data_w(input logic [7:0] op, input logic quad);
    if (quad || op == OP_4IO || op == OP_QOUT || op == OP_QPP) begin
      data_w = 3'h4;
    end else if (op == OP_2IO || op == OP_DOUT) begin
      data_w = 3'h2;
    end else begin
      data_w = 3'h1;
    end
  endfunction

  function automatic logic [3:0] dummy_of(input logic [7:0] op, input logic [1:0] sel);
    case (op)
      OP_RD: dummy_of = 4'h0;
      OP_2IO: dummy_of = DUMMY_2IO[{sel, 2'b00} +: 4];
      OP_4IO: dummy_of = DUMMY_4IO[{sel, 2'b00} +: 4];
      default: dummy_of = DUMMY_1L[{sel, 2'b00} +: 4];
    endcase
  endfunction

  function automatic logic [2:0] exec_code(input logic [7:0] op);
    case (op)
      OP_SEC: exec_code = EX_SEC;
      OP_HBLK: exec_code = EX_HBLK;
      OP_BLK: exec_code = EX_BLK;
      OP_CE0, OP_CE1: exec_code = EX_CHIP;
      OP_QEN: exec_code = EX_QEN;
      OP_QEX: exec_code = EX_QEX;
      default: exec_code = EX_PGM;
    endcase
  endfunction

endpackage

// >>> sfcd_decoder.sv
// How it works
// (RULE1) Page program: address then 1-256 bytes
// (RULE2) Quad page program: single-line only, quad data
// (RULE3) Sector erase: address, no data, both modes
// (RULE4) Half block erase: address, no data
// (RULE5) Block erase: address, no data
// (RULE6) Chip erase: two opcodes, no address
// (RULE7) Normal, fast, two-line reads: single-line only
// (RULE8) Dual and quad output reads: single-line only
// (RULE9) Four-line read: both modes, default six dummies
// (RULE10) Reads stream sequential bytes until select rises
// (RULE11) Dummy count chosen by configuration bits 7:6
// (RULE12) Four address bytes when wide flag set
// (RULE13) Write-type commands need byte-aligned select rise
// (RULE14) Quad instruction mode entered by opcode, held
// (RULE15) Unknown opcode: outputs off until next select
// (RULE16) Single-line-only opcodes unknown in quad mode
`timescale 1ns/100ps
`default_nettype none
module sfcd_decoder import sfcd_pkg::*; (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Serial link pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_sio_in,
  output logic [3:0] o_sio_out,
  output logic [3:0] o_sio_oe,
  // Configuration register bits 6 and 7, address width
  input wire logic i_dummy_count_lsb,
  input wire logic i_dummy_count_msb,
  input wire logic i_wide_address_flag,
  // Array read port
  output logic [31:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  // Program byte stream
  output logic o_pgm_valid,
  output logic [31:0] o_pgm_addr,
  output logic [7:0] o_pgm_data,
  // Operation launch
  output logic o_exec_valid,
  output logic [2:0] o_exec_op,
  output logic [31:0] o_exec_addr,
  output logic o_reject,
  output logic o_quad_instruction_mode
);

  sfcd_regs_t r;
  sfcd_regs_t n;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic [1:0] dc;
  logic [2:0] w;
  logic [2:0] dw;
  logic [5:0] abits;
  logic [5:0] cnt_in;
  logic [31:0] sh_in;
  logic [7:0] byte_src;

  // Edges are seen on the second and third sampling stages only
  assign sclk_rise = r.clk_s[1] && !r.clk_s[2];
  assign sclk_fall = !r.clk_s[1] && r.clk_s[2];
  assign cs_rise = r.cs_s[1] && !r.cs_s[2];
  assign dc = {i_dummy_count_msb, i_dummy_count_lsb}; // RULE11
  assign abits = i_wide_address_flag ? ABITS_WIDE : ABITS_NARROW; // RULE12
  assign dw = data_w(r.op, r.quad);
  assign cnt_in = r.cnt + {3'h0, w};
  assign byte_src = (r.txn == 4'h0) ? i_rd_data : r.tx;

  always_comb begin
    case (r.state)
      S_ADDR: w = addr_w(r.op, r.quad);
      S_WDATA: w = dw;
      default: w = r.quad ? 3'h4 : 3'h1; // RULE14
    endcase
    case (w)
      3'h4: sh_in = {r.sh[27:0], r.io_b};
      3'h2: sh_in = {r.sh[29:0], r.io_b[1:0]};
      default: sh_in = {r.sh[30:0], r.io_b[0]};
    endcase
  end

  always_comb begin
    n = r;
    n.cs_s = {r.cs_s[1:0], i_cs_n};
    n.clk_s = {r.clk_s[1:0], i_sclk};
    n.io_a = i_sio_in;
    n.io_b = r.io_a;
    n.pgm_v = 1'b0;
    n.ex_v = 1'b0;
    n.rej = 1'b0;
    if (cs_rise) begin
      n.state = S_IDLE;
      n.oe = 4'h0; // RULE10
      n.dout = 4'h0;
      // Write-type commands launch only on a whole byte
      if (r.state == S_WDATA) begin
        if (r.cnt == 6'h0 && r.pgm_any) begin
          n.ex_v = 1'b1; // RULE1 RULE2
          n.ex_op = EX_PGM;
        end else begin
          n.rej = 1'b1; // RULE13
        end
      end else if (r.state == S_WAIT) begin
        if (r.cnt[2:0] == 3'h0) begin
          n.ex_v = 1'b1; // RULE13
          n.ex_op = exec_code(r.op);
          if (r.op == OP_QEN) begin
            n.quad = 1'b1; // RULE14
          end else if (r.op == OP_QEX) begin
            n.quad = 1'b0;
          end
        end else begin
          n.rej = 1'b1;
        end
      end else if ((r.state == S_ADDR && cmd_kind(r.op) != K_READ) ||
                   (r.state == S_OPC && r.cnt != 6'h0)) begin
        n.rej = 1'b1; // RULE13
      end
    end else begin
      case (r.state)
        S_IDLE: begin
          if (!r.cs_s[1]) begin
            n.state = S_OPC;
            n.cnt = 6'h0;
            n.txn = 4'h0;
            n.pgm_any = 1'b0;
          end
        end
        S_OPC: begin
          if (sclk_rise) begin
            n.sh = sh_in;
            n.cnt = cnt_in;
            if (cnt_in == BYTE_BITS) begin
              n.op = sh_in[7:0];
              n.cnt = 6'h0;
              if (!cmd_valid(sh_in[7:0], r.quad)) begin
                n.state = S_IGN; // RULE15 RULE16
              end else if (cmd_kind(sh_in[7:0]) == K_NOAD) begin
                n.state = S_WAIT; // RULE6
              end else begin
                n.state = S_ADDR;
              end
            end
          end
        end
        S_ADDR: begin
          if (sclk_rise) begin
            n.sh = sh_in;
            n.cnt = cnt_in;
            if (cnt_in == abits) begin
              n.addr = i_wide_address_flag ? sh_in : {8'h00, sh_in[23:0]}; // RULE12
              n.cnt = 6'h0;
              n.dleft = dummy_of(r.op, dc); // RULE11 RULE9
              case (cmd_kind(r.op))
                K_READ: n.state = (dummy_of(r.op, dc) == 4'h0) ? S_RDATA : S_DUMMY; // RULE7
                K_PGM: n.state = S_WDATA; // RULE1
                default: n.state = S_WAIT; // RULE3 RULE4 RULE5
              endcase
            end
          end
        end
        S_DUMMY: begin
          if (sclk_rise) begin
            n.dleft = r.dleft - 4'h1;
            if (r.dleft == 4'h1) begin
              n.state = S_RDATA;
            end
          end
        end
        S_RDATA: begin
          // Sequential bytes keep coming while the host clocks
          if (sclk_fall) begin
            if (r.txn == 4'h0) begin
              n.addr = r.addr + 32'h1; // RULE10
            end
            case (dw)
              3'h4: begin
                n.dout = byte_src[7:4];
                n.oe = 4'hF; // RULE8 RULE9
                n.tx = {byte_src[3:0], 4'h0};
                n.txn = (r.txn == 4'h0) ? 4'h1 : r.txn - 4'h1;
              end
              3'h2: begin
                n.dout = {2'b00, byte_src[7:6]};
                n.oe = 4'h3; // RULE8
                n.tx = {byte_src[5:0], 2'b00};
                n.txn = (r.txn == 4'h0) ? 4'h3 : r.txn - 4'h1;
              end
              default: begin
                n.dout = {2'b00, byte_src[7], 1'b0};
                n.oe = 4'h2; // RULE7
                n.tx = {byte_src[6:0], 1'b0};
                n.txn = (r.txn == 4'h0) ? 4'h7 : r.txn - 4'h1;
              end
            endcase
          end
        end
        S_WDATA: begin
          if (sclk_rise) begin
            n.sh = sh_in;
            n.cnt = cnt_in;
            if (cnt_in == BYTE_BITS) begin
              n.cnt = 6'h0;
              n.pgm_v = 1'b1; // RULE1 RULE2
              n.pgm_d = sh_in[7:0];
              n.pgm_a = r.addr;
              n.pgm_any = 1'b1;
              // Past the page end the column wraps inside the page
              n.addr = {r.addr[31:8], r.addr[7:0] + 8'h01};
            end
          end
        end
        S_WAIT: begin
          if (sclk_rise) begin
            n.cnt = cnt_in;
          end
        end
        default: begin
          n.oe = 4'h0; // RULE15
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      r <= '0;
      r.cs_s <= 3'h7;
      r.state <= S_IDLE;
    end else begin
      r <= n;
    end
  end

  assign o_sio_out = r.dout;
  assign o_sio_oe = r.oe;
  assign o_rd_addr = r.addr;
  assign o_pgm_valid = r.pgm_v;
  assign o_pgm_addr = r.pgm_a;
  assign o_pgm_data = r.pgm_d;
  assign o_exec_valid = r.ex_v;
  assign o_exec_op = r.ex_op;
  assign o_exec_addr = r.addr;
  assign o_reject = r.rej;
  assign o_quad_instruction_mode = r.quad;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_opc_done;
    r.state == S_OPC && n.state != S_OPC && !cs_rise;
  endsequence
  sequence s_byte_in;
    r.state == S_WDATA && sclk_rise && cnt_in == BYTE_BITS && !cs_rise;
  endsequence

  AST_PGM_BYTE: assert property (s_byte_in // RULE1
      |=> o_pgm_valid && o_pgm_data == $past(sh_in[7:0]))
    else $error("program byte not delivered");
  AST_SPI_ONLY: assert property (s_opc_done ##1 (r.quad && (r.op == OP_QPP || // RULE16
      r.op == OP_RD || r.op == OP_FRD || r.op == OP_2IO || r.op == OP_DOUT ||
      r.op == OP_QOUT)) |-> r.state == S_IGN)
    else $error("single-line opcode accepted in quad mode");
  AST_CHIP_NO_ADDR: assert property (s_opc_done ##1 (r.op == OP_CE0 || r.op == OP_CE1) // RULE6
      |-> r.state == S_WAIT)
    else $error("chip erase expects address");
  AST_IGN_HIZ: assert property (r.state == S_IGN |-> r.oe == 4'h0) // RULE15
    else $error("outputs driven after unknown opcode");
  AST_CS_END: assert property (cs_rise |=> r.oe == 4'h0 && r.state == S_IDLE) // RULE10
    else $error("output still driven after select rise");
  AST_RD_STREAM: assert property (r.state == S_RDATA && sclk_fall && !cs_rise // RULE10
      && r.txn == 4'h0 |=> r.addr == $past(r.addr) + 32'h1)
    else $error("read address did not advance");
  AST_ADDR_LEN: assert property (r.state == S_ADDR && n.state != S_ADDR && !cs_rise // RULE12
      |-> cnt_in == (i_wide_address_flag ? ABITS_WIDE : ABITS_NARROW))
    else $error("wrong address length");
  AST_DUMMY_SEL: assert property (r.state == S_ADDR && n.state == S_DUMMY // RULE11
      |=> r.dleft == dummy_of(r.op, $past(dc)))
    else $error("dummy count not from configuration");
  AST_4IO_DEFAULT: assert property (r.state == S_ADDR && n.state == S_DUMMY // RULE9
      && r.op == OP_4IO && dc == 2'h0 |=> r.dleft == 4'h6)
    else $error("four-line read default dummy not six");
  AST_REJECT: assert property (cs_rise && r.state == S_WDATA && r.cnt != 6'h0 // RULE13
      |=> o_reject && !o_exec_valid)
    else $error("misaligned program not rejected");
  AST_WAIT_REJECT: assert property (cs_rise && r.state == S_WAIT && r.cnt[2:0] != 3'h0 // RULE13
      |=> o_reject && !o_exec_valid)
    else $error("partial byte after erase opcode not rejected");
  AST_QUAD_ENTER: assert property (o_exec_valid && o_exec_op == EX_QEN // RULE14
      |-> o_quad_instruction_mode ##1 o_quad_instruction_mode)
    else $error("quad instruction mode not held");

endmodule
`default_nettype wire

// >>> sfcd_host.sv
`timescale 1ns/100ps
`default_nettype none
module sfcd_host (
  // Clock
  input wire logic i_ref_clk,
  // Link pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_sio,
  input wire logic [3:0] i_sio
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sio = 4'h0;
  end
  task automatic half();
    repeat (4) @(negedge i_ref_clk);
  endtask
  // Clock stands low outside frames
  task automatic open_frame();
    o_cs_n = 1'b0;
    half();
  endtask
  task automatic pulse();
    o_sclk = 1'b1;
    half();
    o_sclk = 1'b0;
    half();
  endtask
  // Lines not carrying data are flipped so stale values never look valid
  task automatic send(input logic [31:0] v, input int nbits, input int lanes);
    for (int i = nbits - lanes; i >= 0; i -= lanes) begin
      o_sio = ~o_sio;
      for (int j = 0; j < lanes; j++) o_sio[j] = v[i + j];
      pulse();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      o_sio = ~o_sio;
      pulse();
    end
  endtask
  // Sampled just before the next fall, well after the device updates
  task automatic recv(output logic [7:0] b, input int lanes);
    for (int i = 8 - lanes; i >= 0; i -= lanes) begin
      o_sio = ~o_sio;
      o_sclk = 1'b1;
      half();
      for (int j = 0; j < lanes; j++) b[i + j] = (lanes == 1) ? i_sio[1] : i_sio[j];
      o_sclk = 1'b0;
      half();
    end
  endtask
  task automatic close_frame();
    half();
    o_cs_n = 1'b1;
    o_sio = ~o_sio;
    repeat (2) half();
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sfcd_pkg::*;
  logic clk, rstn, cs_n, sclk, dc_lsb, dc_msb, wide, pgm_v, ex_v, rej, qmode, oe_seen;
  logic [3:0] host_sio, sio_out, sio_oe, sio;
  logic [31:0] rd_addr, pgm_addr, ex_addr, ex_addr_c;
  logic [7:0] rd_data, pgm_data;
  logic [2:0] ex_op, ex_op_c;
  logic [7:0] pgm_q[$];
  logic [31:0] pgm_aq[$];
  int fails, total_checks, n_ex, n_rej;
  function automatic logic [7:0] mem(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  assign sio = (sio_oe & sio_out) | (~sio_oe & host_sio);
  assign rd_data = mem(rd_addr);
  sfcd_host sfcd_host_inst (.i_ref_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sio(host_sio),
    .i_sio(sio));
  sfcd_decoder sfcd_decoder_inst (.i_ref_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_sio_in(sio), .o_sio_out(sio_out), .o_sio_oe(sio_oe), .i_dummy_count_lsb(dc_lsb),
    .i_dummy_count_msb(dc_msb), .i_wide_address_flag(wide), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .o_pgm_valid(pgm_v), .o_pgm_addr(pgm_addr), .o_pgm_data(pgm_data),
    .o_exec_valid(ex_v), .o_exec_op(ex_op), .o_exec_addr(ex_addr), .o_reject(rej),
    .o_quad_instruction_mode(qmode));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pgm_v === 1'b1) begin
      pgm_q.push_back(pgm_data);
      pgm_aq.push_back(pgm_addr);
    end
    if (ex_v === 1'b1) begin
      n_ex++;
      ex_op_c = ex_op;
      ex_addr_c = ex_addr;
    end
    if (rej === 1'b1) n_rej++;
    if (sio_oe !== 4'h0) oe_seen = 1'b1;
  end
  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input int ol, input logic [31:0] a, input int nab,
    input int al, input int nd);
    n_ex = 0;
    n_rej = 0;
    oe_seen = 1'b0;
    pgm_q.delete();
    pgm_aq.delete();
    sfcd_host_inst.open_frame();
    sfcd_host_inst.send({24'h0, op}, 8, ol);
    if (nab > 0) sfcd_host_inst.send(a, nab * 8, al);
    sfcd_host_inst.idle(nd);
  endtask
  task automatic rd(input int n, input int l, input logic [31:0] a);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      sfcd_host_inst.recv(b, l);
      chk({24'h0, b}, {24'h0, mem(a + i)});
    end
    sfcd_host_inst.close_frame();
  endtask
  task automatic ex(input logic [2:0] op, input logic [31:0] a, input bit ca);
    chk(n_ex, 1);
    chk({29'h0, ex_op_c}, {29'h0, op});
    if (ca) chk(ex_addr_c, a);
  endtask
  // Bytes start near the page end so the column wraps to the page start
  task automatic pgm(input logic [7:0] op, input int ol, input int dl, input logic [31:0] a,
    input int n);
    cmd(op, ol, a, 3, ol, 0);
    for (int i = 0; i < n; i++) sfcd_host_inst.send(32'h3C + i, 8, dl);
    sfcd_host_inst.close_frame();
    chk(pgm_q.size(), n);
    for (int i = 0; i < n && i < pgm_q.size(); i++) begin
      chk({24'h0, pgm_q[i]}, 32'h3C + i);
      chk(pgm_aq[i], {a[31:8], 8'(a[7:0] + i)});
    end
    ex(EX_PGM, {a[31:8], 8'(a[7:0] + n)}, 1'b1);
  endtask
  logic [7:0] er_op[5] = '{OP_SEC, OP_HBLK, OP_BLK, OP_CE0, OP_CE1};
  logic [2:0] er_ex[5] = '{EX_SEC, EX_HBLK, EX_BLK, EX_CHIP, EX_CHIP};
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    {dc_lsb, dc_msb, wide} = 3'h0;
    repeat (10) @(negedge clk);
    chk({27'h0, sio_oe, qmode}, 32'h0);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    cmd(OP_RD, 1, 32'h012345, 3, 1, 0);
    rd(3, 1, 32'h012345);
    {wide, dc_lsb} = 2'h3;
    cmd(OP_FRD, 1, 32'hFFFFFFFF, 4, 1, 6);
    rd(2, 1, 32'hFFFFFFFF);
    {wide, dc_lsb} = 2'h0;
    cmd(OP_DOUT, 1, 32'h00A0F0, 3, 1, 8);
    rd(2, 2, 32'h00A0F0);
    cmd(OP_QOUT, 1, 32'h00B1E1, 3, 1, 8);
    rd(2, 4, 32'h00B1E1);
    dc_msb = 1'b1;
    cmd(OP_2IO, 1, 32'h00C2D2, 3, 2, 8);
    rd(2, 2, 32'h00C2D2);
    dc_msb = 1'b0;
    cmd(OP_4IO, 1, 32'h00D3C3, 3, 4, 6);
    rd(2, 4, 32'h00D3C3);
    for (int k = 0; k < 5; k++) begin
      cmd(er_op[k], 1, 32'h123456, (k < 3) ? 3 : 0, 1, 0);
      sfcd_host_inst.close_frame();
      ex(er_ex[k], 32'h123456, k < 3);
    end
    pgm(OP_PP, 1, 1, 32'h0004FE, 3);
    pgm(OP_QPP, 1, 4, 32'h0007FF, 2);
    cmd(OP_SEC, 1, 32'h001000, 3, 1, 0);
    sfcd_host_inst.send(32'h5, 3, 1);
    sfcd_host_inst.close_frame();
    chk(n_rej, 1);
    chk(n_ex, 0);
    cmd(8'hFF, 1, 0, 0, 1, 0);
    sfcd_host_inst.send(32'h12345678, 32, 1);
    sfcd_host_inst.idle(8);
    sfcd_host_inst.close_frame();
    chk(n_ex + n_rej + oe_seen, 0);
    cmd(OP_QEN, 1, 0, 0, 1, 0);
    sfcd_host_inst.close_frame();
    ex(EX_QEN, 0, 1'b0);
    chk(qmode, 1);
    cmd(OP_RD, 4, 32'h000100, 3, 4, 0);
    sfcd_host_inst.idle(16);
    sfcd_host_inst.close_frame();
    chk(n_ex + oe_seen, 0);
    cmd(OP_SEC, 4, 32'h00ABCD, 3, 4, 0);
    sfcd_host_inst.close_frame();
    ex(EX_SEC, 32'h00ABCD, 1'b1);
    pgm(OP_PP, 4, 4, 32'h0020FF, 2);
    cmd(OP_4IO, 4, 32'h00E4B4, 3, 4, 6);
    rd(3, 4, 32'h00E4B4);
    cmd(OP_QEX, 4, 0, 0, 4, 0);
    sfcd_host_inst.close_frame();
    ex(EX_QEX, 0, 1'b0);
    chk(qmode, 0);
    // Reset in mid-run must drop quad instruction mode
    cmd(OP_QEN, 1, 0, 0, 1, 0);
    sfcd_host_inst.close_frame();
    chk(qmode, 1);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk({27'h0, sio_oe, qmode}, 32'h0);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    {dc_msb, dc_lsb} = 2'h1;
    cmd(OP_2IO, 1, 32'h00F00F, 3, 2, 6);
    rd(1, 2, 32'h00F00F);
    cmd(OP_4IO, 1, 32'h001E2D, 3, 4, 4);
    rd(1, 4, 32'h001E2D);
    {dc_msb, dc_lsb} = 2'h3;
    cmd(OP_4IO, 1, 32'h003C4B, 3, 4, 10);
    rd(1, 4, 32'h003C4B);
    cmd(OP_FRD, 1, 32'h005A69, 3, 1, 10);
    rd(1, 1, 32'h005A69);
    {dc_msb, dc_lsb} = 2'h0;
    wide = 1'b1;
    cmd(OP_BLK, 1, 32'h01234567, 4, 1, 0);
    sfcd_host_inst.close_frame();
    ex(EX_BLK, 32'h01234567, 1'b1);
    wide = 1'b0;
    // A program with no data byte is refused
    cmd(OP_PP, 1, 32'h000300, 3, 1, 0);
    sfcd_host_inst.close_frame();
    chk(n_rej, 1);
    chk(n_ex, 0);
    cmd(OP_PP, 1, 32'h000300, 3, 1, 0);
    sfcd_host_inst.send(32'hA5, 8, 1);
    sfcd_host_inst.send(32'h5, 3, 1);
    sfcd_host_inst.close_frame();
    chk(pgm_q.size(), 1);
    chk(n_rej, 1);
    chk(n_ex, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
